// File: hdl/pstb_map.vh
// Register offsets, field positions and reset values of the secondary time base control.
// Assumes a 32-bit APB with byte addresses; every register sits on one aligned word.
`ifndef PSTB_MAP_VH
`define PSTB_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PSTB_CTRL_OFS 8'h00
`define PSTB_PER_OFS 8'h04
`define PSTB_CMP_OFS 8'h08
`define PSTB_STAT_OFS 8'h0c
`define PSTB_MASK_OFS 8'h10
`define PSTB_TMR_OFS 8'h14
`define PSTB_EN_OFS 8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PSTB_PS_LSB 0
`define PSTB_PS_MSB 3
`define PSTB_SRC_LSB 4
`define PSTB_SRC_MSB 6
`define PSTB_EXTERNAL_SYNC_ENABLE_BIT 7
`define PSTB_SOEN_BIT 8
`define PSTB_POL_BIT 9
`define PSTB_IMM_BIT 10
`define PSTB_IEN_BIT 11
`define PSTB_PEND_BIT 12

// ----------------------------------------
// Sync source codes
// ----------------------------------------
`define PSTB_SRC_ONE 3'h0
`define PSTB_SRC_TWO 3'h1

// ----------------------------------------
// Status and mask bits
// ----------------------------------------
`define PSTB_ST_EVT 0
`define PSTB_ST_BND 1
`define PSTB_ST_SYNC 2

// ----------------------------------------
// Compare field and reset values
// ----------------------------------------
`define PSTB_CMP_LSB 3
`define PSTB_CMP_MSB 15
`define PSTB_CTRL_RST 12'h000
`define PSTB_PER_RST 16'hffff
`define PSTB_CMP_RST 13'h0000
`define PSTB_MASK_RST 3'h0

`endif

// File: hdl/pstb_sync_sel.v
// Routes one of the external sync inputs to the time base.
// Assumes inputs already synchronous to the bus clock.
`timescale 1ns/1ns
`include "pstb_map.vh"

module pstb_sync_sel
(
    // Selection
    input wire [2:0] src,
    // Sync inputs
    input wire sync_input_one,
    input wire sync_input_two,
    // Result
    output reg sel_level
);

    // Reserved codes pick a constant low level; the top gates them so a bad setting never syncs
    always @*
    begin
        case (src)
            `PSTB_SRC_ONE: sel_level = sync_input_one;
            `PSTB_SRC_TWO: sel_level = sync_input_two;
            default: sel_level = 1'b0;
        endcase
    end

endmodule

// File: hdl/pstb_postscale.v
// Postscaler for the special event trigger: one trigger per ratio+1 matches.
// Assumes match is a one-cycle pulse.
`timescale 1ns/1ns

module pstb_postscale
#(
    parameter PW = 4
)
(
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire clear,
    input wire [PW-1:0] ratio,
    input wire match,
    // Result
    output wire trig
);

    reg [PW-1:0] cnt_q;

    // Count reaching the field value means field+1 matches seen
    assign trig = match && (cnt_q >= ratio);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= {PW{1'b0}};
        else if (clear)
            cnt_q <= {PW{1'b0}};
        else if (trig)
            cnt_q <= {PW{1'b0}};
        else if (match)
            cnt_q <= cnt_q + 1'b1;
    end

endmodule

// File: hdl/pstb_top.v
// Secondary master time base with its control register, behind an APB slave.
// Assumes all inputs synchronous to pclk; one zero-wait APB master.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "pstb_map.vh"

// How it works
// - With immediate update set a written period loads at once, else at the next boundary or while the time base is stopped.
// - The immediate update option touches only this secondary time base period.
// - The polarity bit makes sync input and sync output active-low when set.
// - The special event interrupt can only be raised while its enable bit is set.
// - The sync output pulses at boundaries when enabled and stays inactive otherwise.
// - The selected external sync restarts the time base only while sync enable is set.
// - Source code 000 picks sync input one, 001 input two, others pick nothing.
// - The postscaler ratio is the four-bit field value plus one.
// - The postscaler counts compare matches and emits one trigger per ratio.
module pstb_top
#(
    parameter TW = 16,
    parameter CW = 13
)
(
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // External sync
    input wire sync_input_one,
    input wire sync_input_two,
    output reg sync_out,
    // Events
    output reg event_trigger,
    output reg period_boundary,
    output reg irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Level as seen through the polarity bit
    function pstb_asserted;
        input level;
        input pol;
        begin
            pstb_asserted = level ^ pol;
        end
    endfunction

    function pstb_known;
        input [7:0] addr;
        begin
            case (addr)
                `PSTB_CTRL_OFS: pstb_known = 1'b1;
                `PSTB_PER_OFS: pstb_known = 1'b1;
                `PSTB_CMP_OFS: pstb_known = 1'b1;
                `PSTB_STAT_OFS: pstb_known = 1'b1;
                `PSTB_MASK_OFS: pstb_known = 1'b1;
                `PSTB_TMR_OFS: pstb_known = 1'b1;
                `PSTB_EN_OFS: pstb_known = 1'b1;
                default: pstb_known = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------

    reg [11:0] ctrl_q;
    reg [TW-1:0] per_buf_q;
    reg [TW-1:0] per_act_q;
    reg [CW-1:0] cmp_q;
    reg [2:0] stat_q;
    reg [2:0] stat_d;
    reg [2:0] mask_q;
    reg en_q;
    reg [TW-1:0] tmr_q;
    reg sync_prev_q;
    reg [31:0] rd_mux;
    reg src_ok;

    wire acc_wr;
    wire run;
    wire pol;
    wire sel_level;
    wire sync_now;
    wire sync_hit;
    wire at_end;
    wire boundary;
    wire match;
    wire trig;
    wire evt_set;
    wire [TW-1:0] cmp_full;
    wire [2:0] sync_src;

    // ----------------------------------------
    // APB access
    // ----------------------------------------

    // Write lands at the access edge where pready is sampled high
    assign acc_wr = psel && penable && pwrite && pready;

    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `PSTB_CTRL_OFS:
            begin
                rd_mux[11:0] = ctrl_q;
                rd_mux[`PSTB_PEND_BIT] = stat_q[`PSTB_ST_EVT];
            end
            `PSTB_PER_OFS:
                rd_mux[TW-1:0] = per_buf_q;
            `PSTB_CMP_OFS:
                rd_mux[`PSTB_CMP_MSB:`PSTB_CMP_LSB] = cmp_q;
            `PSTB_STAT_OFS:
                rd_mux[2:0] = stat_q;
            `PSTB_MASK_OFS:
                rd_mux[2:0] = mask_q;
            `PSTB_TMR_OFS:
                rd_mux[TW-1:0] = tmr_q;
            `PSTB_EN_OFS:
                rd_mux[0] = en_q;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // Answer is ready in the first access cycle: no wait states
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !pstb_known(paddr);
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------

    // Pending flag lives in the status word, so it is not stored here
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `PSTB_CTRL_RST;
            per_buf_q <= `PSTB_PER_RST;
            cmp_q <= `PSTB_CMP_RST;
            mask_q <= `PSTB_MASK_RST;
            en_q <= 1'b0;
        end
        else if (acc_wr)
        begin
            case (paddr)
                `PSTB_CTRL_OFS:
                    ctrl_q <= pwdata[11:0];
                `PSTB_PER_OFS:
                    per_buf_q <= pwdata[TW-1:0];
                `PSTB_CMP_OFS:
                    cmp_q <= pwdata[`PSTB_CMP_MSB:`PSTB_CMP_LSB];
                `PSTB_MASK_OFS:
                    mask_q <= pwdata[2:0];
                `PSTB_EN_OFS:
                    en_q <= pwdata[0];
                default:
                    en_q <= en_q;
            endcase
        end
    end

    assign run = en_q;
    assign pol = ctrl_q[`PSTB_POL_BIT];

    // ----------------------------------------
    // Active period
    // ----------------------------------------

    // Only the secondary period is double-buffered here
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            per_act_q <= `PSTB_PER_RST;
        else if (acc_wr && paddr == `PSTB_PER_OFS && ctrl_q[`PSTB_IMM_BIT])
            per_act_q <= pwdata[TW-1:0];
        else if (boundary || !run)
            per_act_q <= per_buf_q;
    end

    // ----------------------------------------
    // External sync
    // ----------------------------------------

    assign sync_src = ctrl_q[`PSTB_SRC_MSB:`PSTB_SRC_LSB];

    // A reserved code yields a low level, which an inverted polarity reads
    // as active, so the code itself must gate the sync path
    always @*
    begin
        case (sync_src)
            `PSTB_SRC_ONE: src_ok = 1'b1;
            `PSTB_SRC_TWO: src_ok = 1'b1;
            default: src_ok = 1'b0;
        endcase
    end

    pstb_sync_sel u_sel
    (
        .src(sync_src),
        .sync_input_one(sync_input_one),
        .sync_input_two(sync_input_two),
        .sel_level(sel_level)
    );

    assign sync_now = src_ok && pstb_asserted(sel_level, pol);

    // Edge, not level, so a long sync pulse restarts the count once
    assign sync_hit = run && ctrl_q[`PSTB_EXTERNAL_SYNC_ENABLE_BIT] && sync_now && !sync_prev_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_prev_q <= 1'b0;
        else
            sync_prev_q <= sync_now;
    end

    // ----------------------------------------
    // Timer
    // ----------------------------------------

    // >= guards against a period shrunk below the running count
    assign at_end = tmr_q >= per_act_q;
    assign boundary = run && (at_end || sync_hit);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tmr_q <= {TW{1'b0}};
        else if (!run || boundary)
            tmr_q <= {TW{1'b0}};
        else
            tmr_q <= tmr_q + 1'b1;
    end

    // ----------------------------------------
    // Special event
    // ----------------------------------------

    assign cmp_full = {cmp_q, 3'h0};
    assign match = run && (tmr_q == cmp_full);

    pstb_postscale #(.PW(4)) u_ps
    (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!run),
        .ratio(ctrl_q[`PSTB_PS_MSB:`PSTB_PS_LSB]),
        .match(match),
        .trig(trig)
    );

    assign evt_set = trig && ctrl_q[`PSTB_IEN_BIT];

    // ----------------------------------------
    // Status and interrupt
    // ----------------------------------------

    // Set beats a same-cycle write-one-to-clear
    always @*
    begin
        stat_d = stat_q;
        if (acc_wr && paddr == `PSTB_STAT_OFS)
            stat_d = stat_q & ~pwdata[2:0];
        if (!ctrl_q[`PSTB_IEN_BIT])
            stat_d[`PSTB_ST_EVT] = 1'b0;
        if (evt_set)
            stat_d[`PSTB_ST_EVT] = 1'b1;
        if (boundary)
            stat_d[`PSTB_ST_BND] = 1'b1;
        if (sync_hit)
            stat_d[`PSTB_ST_SYNC] = 1'b1;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            irq <= |(stat_d & mask_q);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Idle level follows polarity, so active-low idles high
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_out <= 1'b0;
            event_trigger <= 1'b0;
            period_boundary <= 1'b0;
        end
        else
        begin
            if (ctrl_q[`PSTB_SOEN_BIT])
                sync_out <= pstb_asserted(boundary, pol);
            else
                sync_out <= pol;
            event_trigger <= trig;
            period_boundary <= boundary;
        end
    end

endmodule

// File: bench/pstb_checker.sv
// Port assertions for the secondary time base block.
// Assumes one APB master; bound to the top from the bench.
`timescale 1ns/1ns

module pstb_checker
(
    // Clock, reset, APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Outputs
    input wire sync_out,
    input wire event_trigger,
    input wire period_boundary
);
    // Shadow of polarity and sync output enable, delayed as the output is registered
    logic [1:0] c_q;
    logic [1:0] c_p;
    wire bad = (paddr[1:0] != 2'h0) || (paddr > 8'h18);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c_q <= 2'h0;
            c_p <= 2'h0;
        end
        else
        begin
            c_p <= c_q;
            if (psel && penable && pready && pwrite && paddr == 8'h00)
                c_q <= pwdata[9:8];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_RDY: assert property (psel && !penable |=> pready)
        else $error("No ready after setup");
    AST_ERR_BAD: assert property (psel && !penable && bad |=> pslverr)
        else $error("Unmapped access not refused");
    AST_ERR_OK: assert property (psel && !penable && !bad |=> !pslverr)
        else $error("Mapped access refused");
    AST_RD_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("Refused read not zero");
    AST_BND_ONE: assert property (period_boundary |=> !period_boundary)
        else $error("Boundary pulse too long");
    AST_TRIG_ONE: assert property (event_trigger |=> !event_trigger)
        else $error("Trigger pulse too long");
    AST_SYNC_IDLE: assert property (sync_out != c_p[1] |-> period_boundary && c_p[0])
        else $error("Sync output active without cause");
    AST_SYNC_ACT: assert property (period_boundary && c_p[0] |-> sync_out != c_p[1])
        else $error("Sync output level wrong");
    cover property (event_trigger);
    cover property (sync_out != c_p[1]);
    cover property (pslverr);
endmodule

// File: bench/pstb_sync_src.sv
// Model of the two external sync sources.
// Assumes fire requests are one-cycle pulses; hold sets how slow a source is.
`timescale 1ns/1ns

module pstb_sync_src
(
    // Clock and control
    input wire pclk,
    input wire pol,
    input wire [1:0] fire,
    input wire [3:0] hold,
    // Sync lines
    output wire sync_input_one,
    output wire sync_input_two
);
    logic [3:0] a_q = 4'h0;
    logic [3:0] b_q = 4'h0;
    always @(posedge pclk)
    begin
        a_q <= fire[0] ? hold : a_q - {3'h0, a_q != 4'h0};
        b_q <= fire[1] ? hold : b_q - {3'h0, b_q != 4'h0};
    end
    // Idle level is the polarity bit, so a polarity change alone is no edge
    assign sync_input_one = (a_q != 4'h0) ^ pol;
    assign sync_input_two = (b_q != 4'h0) ^ pol;
endmodule

// File: bench/pstb_tb.sv
// Self-checking bench for the secondary time base block.
// Assumes zero-wait APB answers and the sync source model beside it.
`timescale 1ns/1ns

module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pol = 1'b0;
    logic [1:0] fire = 2'h0;
    logic [3:0] hold = 4'h1;
    logic [31:0] rd;
    logic [2:0] s;
    logic er;
    wire [31:0] prdata;
    wire pready, pslverr, sync_out, event_trigger, period_boundary, irq;
    wire sync_input_one, sync_input_two;
    int mismatches = 0;
    int checked = 0;
    int n, p;

    pstb_top pstb_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sync_input_one, .sync_input_two, .sync_out,
        .event_trigger, .period_boundary, .irq);
    pstb_sync_src pstb_sync_src_i (.pclk, .pol, .fire, .hold, .sync_input_one,
        .sync_input_two);

    always #5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task automatic results;
    begin
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    // One transfer, then an idle edge so the next setup never collides
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 16)
        begin
            mismatches++;
            results;
        end
    end
    endtask

    // Edges until a boundary (sel 0) or trigger (sel 1) is seen, -1 if none
    task automatic wf(input logic sel, input int lim, input logic must, output int c);
        logic hit;
    begin
        c = 0;
        hit = 1'b0;
        while (!hit && c < lim)
        begin
            @(posedge pclk);
            c++;
            hit = ((sel ? event_trigger : period_boundary) === 1'b1);
        end
        if (!hit)
            c = -1;
        if (!hit && must)
        begin
            mismatches++;
            results;
        end
    end
    endtask

    initial
    begin
        n = $urandom(32'h7f55a5fe);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, (i == 1) ? 32'hffff : 32'h0);
            chk(er, i == 7);
        end
        apb(1'b1, 8'h14, 32'h55);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        repeat (4)
        begin
            p = $urandom;
            apb(1'b1, 8'h00, p | 32'h1000);
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, p & 32'hfff);
        end
        p = $urandom_range(24, 40);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, p);
        apb(1'b1, 8'h08, 32'h8);
        apb(1'b1, 8'h18, 32'h1);
        wf(1'b0, 200, 1'b1, n);
        wf(1'b0, 200, 1'b1, n);
        chk(n, p + 1);
        apb(1'b1, 8'h04, p + 7);
        wf(1'b0, 200, 1'b1, n);
        chk(n + 3, p + 1);
        wf(1'b0, 200, 1'b1, n);
        chk(n, p + 8);
        apb(1'b1, 8'h00, 32'h400);
        wf(1'b0, 200, 1'b1, n);
        p = p + 30;
        apb(1'b1, 8'h04, p);
        wf(1'b0, 200, 1'b1, n);
        chk(n + 3, p + 1);
        for (int k = 0; k < 16; k++)
        begin
            apb(1'b1, 8'h18, 32'h0);
            apb(1'b1, 8'h00, 32'h800 | k);
            apb(1'b1, 8'h18, 32'h1);
            wf(1'b1, 2000, 1'b1, n);
            wf(1'b1, 2000, 1'b1, n);
            chk(n, (k + 1) * (p + 1));
        end
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h180f);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd[0], 1'b1);
        chk(irq, 1'b0);
        apb(1'b1, 8'h10, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h0c, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h80f);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h18, 32'h1);
        wf(1'b1, 200, 1'b1, n);
        wf(1'b1, 200, 1'b1, n);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd[0], 1'b0);
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h04, 32'hc8);
        for (int i = 0; i < 24; i++)
        begin
            s = (i < 16) ? 3'(i / 8) : 3'($urandom_range(2, 7));
            apb(1'b1, 8'h18, 32'h0);
            pol <= i[2];
            hold <= 4'($urandom_range(1, 15));
            apb(1'b1, 8'h00, {i[2], i[1], i[1], s, 4'h0});
            apb(1'b1, 8'h18, 32'h1);
            wf(1'b0, 400, 1'b1, n);
            chk(sync_out, i[1] ^ i[2]);
            repeat (5) @(posedge pclk);
            fire[i[0]] <= 1'b1;
            @(posedge pclk);
            fire <= 2'h0;
            wf(1'b0, 8, 1'b0, n);
            chk(n > 0, i[1] && s == 3'(i[0]));
        end
        results;
    end
endmodule

bind pstb_top pstb_checker pstb_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sync_out, .event_trigger,
    .period_boundary);
